/* File: sic_bus_cond.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Clock edges and start / stop conditions of the serial bus
// ----------------------------------------------------------------------------
module sic_bus_cond (
  input  wire clk,
  input  wire resetn,
  input  wire scl_s,
  input  wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);

  reg scl_q_ff;
  reg sda_q_ff;

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end
    else
    begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q_ff;
  assign scl_fall  = ~scl_s & scl_q_ff;
  // Data may only move while the clock is low; a move with clock high frames
  assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

endmodule // sic_bus_cond

/* File: sic_i2c_mst.sv */
`timescale 1ns/10ps

// ----
// Serial bus master; clock is driven high at idle, data line idles high through pull-up
// ----
module sic_i2c_mst #(
  parameter HALF = 8
) (
  input  wire  clk,
  input  wire  sda_line,
  output logic scl,
  output logic sda_pull
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start;
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
  endtask

  // data moves only while clock low
  task automatic bit_io(input logic b, output logic s);
    tick(HALF);
    sda_pull <= !b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    s = sda_line;
    scl <= 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask

  task automatic stop;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask
endmodule // sic_i2c_mst

/* File: sic_regs.vh */
`ifndef SIC_REGS_VH
`define SIC_REGS_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SIC_IDX_TX_FIRST   6'h18
`define SIC_IDX_TX_SECOND  6'h19
`define SIC_IDX_CTRL       6'h1a
`define SIC_IDX_FLAGS      6'h1b
`define SIC_IDX_RX_FIRST   6'h20
`define SIC_IDX_RX_SECOND  6'h21
`define SIC_IDX_IRQ_MASK   6'h22

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SIC_CTRL_IE        4
`define SIC_CTRL_EN        3
`define SIC_CTRL_ID_HI     1
`define SIC_CTRL_ID_LO     0
`define SIC_CTRL_RD_MASK   8'h1b

// ----------------------------------------------------------------------------
// Event flag fields (mask register shares the layout)
// ----------------------------------------------------------------------------
`define SIC_FLG_PEND       6
`define SIC_FLG_TX_SECOND  5
`define SIC_FLG_TX_FIRST   4
`define SIC_FLG_RX2_OVF    3
`define SIC_FLG_RX2_DONE   2
`define SIC_FLG_RX1_OVF    1
`define SIC_FLG_RX1_DONE   0
`define SIC_FLG_IMPL_MASK  8'h7f

// ----------------------------------------------------------------------------
// Reset values and defaults
// ----------------------------------------------------------------------------
`define SIC_RST_BYTE       8'h00
`define SIC_RST_IRQ_MASK   8'h7f
`define SIC_ADDR_HIGH_DEF  5'h0a
`define SIC_BITS_PER_BYTE  4'h8

`endif

/* File: sic_sync.v */
`timescale 1ns/10ps

// ----------------------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ----------------------------------------------------------------------------
module sic_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] d_in,
  output wire [W-1:0] d_sync
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // Idle bus is high, so both stages reset high to avoid a false start
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end
    else
    begin
      meta_ff <= d_in;
      sync_ff <= meta_ff;
    end
  end

  assign d_sync = sync_ff;

endmodule // sic_sync

/* File: sic_top.v */
// Notes on behaviour
// - First transmit byte register, reset zero
// - Second transmit byte register, reset zero
// - Enable bit; off means bus ignored
// - Two low address bits from software
// - Any event sets pending; enable gates interrupt
// - Second transmit done flag, write zero clears
// - First transmit done flag, write zero clears
// - Second receive overflow flag, write zero clears
// - Second receive done flag, write zero clears
// - First receive overflow flag, write zero clears
// - Pending flag cleared by writing zero
`timescale 1ns/10ps
`include "sic_regs.vh"

module sic_top #(
  parameter [4:0] ADDR_HIGH = `SIC_ADDR_HIGH_DEF
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output wire        irq_o,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe
);

  // --------------------------------------------------------------------------
  // Serial engine states
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_ADDR     = 3'h1;
  localparam [2:0] ST_ADDR_ACK = 3'h2;
  localparam [2:0] ST_WR_BYTE  = 3'h3;
  localparam [2:0] ST_WR_ACK   = 3'h4;
  localparam [2:0] ST_RD_BYTE  = 3'h5;
  localparam [2:0] ST_RD_ACK   = 3'h6;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [7:0]  tx_hold_first_ff;
  reg  [7:0]  tx_hold_second_ff;
  reg  [7:0]  serial_control_ff;
  reg  [7:0]  event_flag_ff;
  reg  [7:0]  irq_mask_ff;
  reg  [7:0]  rx_data_first_ff;
  reg  [7:0]  rx_data_second_ff;
  reg  [1:0]  rx_full_ff;
  reg  [2:0]  state_ff;
  reg  [3:0]  cnt_ff;
  reg  [7:0]  shift_ff;
  reg         rw_ff;
  reg         slot_ff;
  reg         nack_ff;
  reg         sda_oe_ff;
  reg         sda_o_ff;
  reg         ack_ff;
  reg  [31:0] dat_ff;
  reg         irq_ff;

  reg  [2:0]  nxt_state;
  reg  [3:0]  nxt_cnt;
  reg  [7:0]  nxt_shift;
  reg         nxt_rw;
  reg         nxt_slot;
  reg         nxt_nack;
  reg         nxt_sda_oe;
  reg  [1:0]  ev_rx;
  reg  [1:0]  ev_tx;
  reg  [7:0]  rd_val;
  reg  [7:0]  nxt_flags;
  reg  [1:0]  nxt_rx_full;

  wire [1:0]  pins_s;
  wire        scl_s;
  wire        sda_s;
  wire        scl_rise;
  wire        scl_fall;
  wire        start_det;
  wire        stop_det;
  wire        iface_en;
  wire [1:0]  addr_low;
  wire        bus_req;
  wire        bus_wr;
  wire        bus_rd;
  wire [1:0]  ev_ovf;
  wire [7:0]  flag_set;
  wire [7:0]  flag_clr;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function hit;
    input [7:0] adr;
    input [5:0] idx;
    begin
      hit = (adr[7:2] == idx);
    end
  endfunction

  function [7:0] tx_pick;
    input       slot;
    input [7:0] first;
    input [7:0] second;
    begin
      tx_pick = slot ? second : first;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisation and bus conditions
  // --------------------------------------------------------------------------
  sic_sync #(
    .W (2)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d_in   ({scl_i, sda_i}),
    .d_sync (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  sic_bus_cond u_cond (
    .clk       (clk),
    .resetn    (resetn),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  assign iface_en = serial_control_ff[`SIC_CTRL_EN];
  assign addr_low = serial_control_ff[`SIC_CTRL_ID_HI:`SIC_CTRL_ID_LO];

  // --------------------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------------------
  always @*
  begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_shift  = shift_ff;
    nxt_rw     = rw_ff;
    nxt_slot   = slot_ff;
    nxt_nack   = nack_ff;
    nxt_sda_oe = sda_oe_ff;
    ev_rx      = 2'h0;
    ev_tx      = 2'h0;
    if (!iface_en)
    begin
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else if (stop_det)
    begin
      nxt_state  = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else if (start_det)
    begin
      nxt_state  = ST_ADDR;
      nxt_cnt    = 4'h0;
      nxt_sda_oe = 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          nxt_sda_oe = 1'b0;
        end
        ST_ADDR, ST_WR_BYTE:
        begin
          if (scl_rise)
          begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt   = cnt_ff + 4'h1;
          end
          else if (scl_fall && cnt_ff == `SIC_BITS_PER_BYTE)
          begin
            if (state_ff == ST_ADDR)
            begin
              if (shift_ff[7:1] == {ADDR_HIGH, addr_low})
              begin
                nxt_sda_oe = 1'b1;
                nxt_rw     = shift_ff[0];
                nxt_slot   = 1'b0;
                nxt_state  = ST_ADDR_ACK;
              end
              else
              begin
                nxt_state = ST_IDLE;
              end
            end
            else
            begin
              ev_rx[slot_ff] = 1'b1;
              nxt_sda_oe     = 1'b1;
              nxt_slot       = ~slot_ff;
              nxt_state      = ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            nxt_cnt = 4'h0;
            if (rw_ff)
            begin
              nxt_shift  = tx_pick(slot_ff, tx_hold_first_ff, tx_hold_second_ff);
              nxt_sda_oe = ~nxt_shift[7];
              nxt_state  = ST_RD_BYTE;
            end
            else
            begin
              nxt_sda_oe = 1'b0;
              nxt_state  = ST_WR_BYTE;
            end
          end
        end
        ST_RD_BYTE:
        begin
          if (scl_rise)
          begin
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (scl_fall)
          begin
            if (cnt_ff == `SIC_BITS_PER_BYTE)
            begin
              ev_tx[slot_ff] = 1'b1;
              nxt_slot       = ~slot_ff;
              nxt_sda_oe     = 1'b0;
              nxt_state      = ST_RD_ACK;
            end
            else
            begin
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        ST_RD_ACK:
        begin
          if (scl_rise)
          begin
            nxt_nack = sda_s;
          end
          else if (scl_fall)
          begin
            nxt_cnt = 4'h0;
            if (nack_ff)
            begin
              nxt_state = ST_IDLE;
            end
            else
            begin
              nxt_shift  = tx_pick(slot_ff, tx_hold_first_ff, tx_hold_second_ff);
              nxt_sda_oe = ~nxt_shift[7];
              nxt_state  = ST_RD_BYTE;
            end
          end
        end
        default:
        begin
          nxt_state  = ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_rd  = bus_req & ~wb_we_i;

  always @*
  begin
    rd_val = 8'h00;
    if (hit(wb_adr_i, `SIC_IDX_TX_FIRST))
      rd_val = tx_hold_first_ff;
    else if (hit(wb_adr_i, `SIC_IDX_TX_SECOND))
      rd_val = tx_hold_second_ff;
    else if (hit(wb_adr_i, `SIC_IDX_CTRL))
      rd_val = serial_control_ff & `SIC_CTRL_RD_MASK;
    else if (hit(wb_adr_i, `SIC_IDX_FLAGS))
      rd_val = event_flag_ff;
    else if (hit(wb_adr_i, `SIC_IDX_RX_FIRST))
      rd_val = rx_data_first_ff;
    else if (hit(wb_adr_i, `SIC_IDX_RX_SECOND))
      rd_val = rx_data_second_ff;
    else if (hit(wb_adr_i, `SIC_IDX_IRQ_MASK))
      rd_val = irq_mask_ff;
  end

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  // overflow when unread byte is replaced
  assign ev_ovf = ev_rx & rx_full_ff;

  assign flag_set = {1'b0, (|ev_rx) | (|ev_tx), ev_tx[1], ev_tx[0],
                     ev_ovf[1], ev_rx[1], ev_ovf[0], ev_rx[0]};

  assign flag_clr = (bus_wr && hit(wb_adr_i, `SIC_IDX_FLAGS)) ? ~wb_dat_i[7:0] : 8'h00;

  always @*
  begin
    nxt_flags = ((event_flag_ff & ~flag_clr) | flag_set) & `SIC_FLG_IMPL_MASK;
    nxt_rx_full = rx_full_ff;
    if (bus_rd && hit(wb_adr_i, `SIC_IDX_RX_FIRST))
      nxt_rx_full[0] = 1'b0;
    if (bus_rd && hit(wb_adr_i, `SIC_IDX_RX_SECOND))
      nxt_rx_full[1] = 1'b0;
    nxt_rx_full = nxt_rx_full | ev_rx;
  end

  // --------------------------------------------------------------------------
  // Flip-flops
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_hold_first_ff  <= `SIC_RST_BYTE;
      tx_hold_second_ff <= `SIC_RST_BYTE;
      serial_control_ff <= `SIC_RST_BYTE;
      event_flag_ff     <= `SIC_RST_BYTE;
      irq_mask_ff       <= `SIC_RST_IRQ_MASK;
      rx_data_first_ff  <= `SIC_RST_BYTE;
      rx_data_second_ff <= `SIC_RST_BYTE;
      rx_full_ff        <= 2'h0;
      state_ff          <= ST_IDLE;
      cnt_ff            <= 4'h0;
      shift_ff          <= 8'h00;
      rw_ff             <= 1'b0;
      slot_ff           <= 1'b0;
      nack_ff           <= 1'b0;
      sda_oe_ff         <= 1'b0;
      sda_o_ff          <= 1'b0;
      ack_ff            <= 1'b0;
      dat_ff            <= 32'h0000_0000;
      irq_ff            <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      shift_ff  <= nxt_shift;
      rw_ff     <= nxt_rw;
      slot_ff   <= nxt_slot;
      nack_ff   <= nxt_nack;
      sda_oe_ff <= nxt_sda_oe;
      // Open drain: only ever pulls low
      sda_o_ff  <= 1'b0;
      ack_ff    <= bus_req;
      dat_ff    <= bus_rd ? {24'h00_0000, rd_val} : 32'h0000_0000;
      if (bus_wr && hit(wb_adr_i, `SIC_IDX_TX_FIRST))
        tx_hold_first_ff <= wb_dat_i[7:0];
      if (bus_wr && hit(wb_adr_i, `SIC_IDX_TX_SECOND))
        tx_hold_second_ff <= wb_dat_i[7:0];
      if (bus_wr && hit(wb_adr_i, `SIC_IDX_CTRL))
        serial_control_ff <= wb_dat_i[7:0] & `SIC_CTRL_RD_MASK;
      if (bus_wr && hit(wb_adr_i, `SIC_IDX_IRQ_MASK))
        irq_mask_ff <= wb_dat_i[7:0] & `SIC_FLG_IMPL_MASK;
      // Overflow keeps the newest byte; the older one is lost
      if (ev_rx[0])
        rx_data_first_ff <= shift_ff;
      if (ev_rx[1])
        rx_data_second_ff <= shift_ff;
      rx_full_ff    <= nxt_rx_full;
      event_flag_ff <= nxt_flags;
      irq_ff <= serial_control_ff[`SIC_CTRL_IE] & (|(event_flag_ff & irq_mask_ff));
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign irq_o    = irq_ff;
  assign sda_o    = sda_o_ff;
  assign sda_oe   = sda_oe_ff;

endmodule // sic_top

/* File: sic_top_properties.sv */
`timescale 1ns/10ps
`include "sic_regs.vh"

module sic_top_props (
  input wire        clk,
  input wire        resetn,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        irq_o,
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe
);
  reg  [7:0] tx1_ff;
  reg  [7:0] tx2_ff;
  reg  [7:0] ctl_ff;
  wire [5:0] idx = wb_adr_i[7:2];
  wire       wtake = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  wire       rdack = wb_ack_o && !wb_we_i;

  // ----
  // Shadow of software writes, taken on the same edge as the design
  // ----
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx1_ff <= 8'h00;
      tx2_ff <= 8'h00;
      ctl_ff <= 8'h00;
    end
    else if (wtake)
    begin
      if (idx == `SIC_IDX_TX_FIRST) tx1_ff <= wb_dat_i[7:0];
      if (idx == `SIC_IDX_TX_SECOND) tx2_ff <= wb_dat_i[7:0];
      if (idx == `SIC_IDX_CTRL) ctl_ff <= wb_dat_i[7:0] & `SIC_CTRL_RD_MASK;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  property p_tx1_rd;
    rdack && idx == `SIC_IDX_TX_FIRST |-> wb_dat_o[7:0] == tx1_ff;
  endproperty
  a_tx1_rd: assert property (p_tx1_rd) else $error("first byte read");
  property p_tx2_rd;
    rdack && idx == `SIC_IDX_TX_SECOND |-> wb_dat_o[7:0] == tx2_ff;
  endproperty
  a_tx2_rd: assert property (p_tx2_rd) else $error("second byte read");
  property p_ctl_rd;
    rdack && idx == `SIC_IDX_CTRL |-> wb_dat_o[7:0] == ctl_ff;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
  property p_en_gate;
    !ctl_ff[3] && !$past(ctl_ff[3]) |-> !sda_oe;
  endproperty
  a_en_gate: assert property (p_en_gate) else $error("drive while off");
  property p_irq_gate;
    !ctl_ff[4] && !$past(ctl_ff[4]) |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while off");
  // Data line drive may only move while the clock is low or within four cycles of its rise
  property p_oe_still;
    scl_i && $past(scl_i) && $past(scl_i, 2) && $past(scl_i, 3) && $past(scl_i, 4)
      |-> $stable(sda_oe);
  endproperty
  a_oe_still: assert property (p_oe_still) else $error("data moved in high");

  c_rx_rd: cover property (rdack && idx == `SIC_IDX_RX_FIRST);
  c_irq: cover property ($rose(irq_o));
  c_oe: cover property ($rose(sda_oe));
endmodule // sic_top_props

bind sic_top sic_top_props u_props (
  .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

/* File: tb_slave_i2c_register_interface.sv */
`timescale 1ns/10ps
`include "sic_regs.vh"

module tb_slave_i2c_register_interface;
  localparam logic [4:0] AH = 5'h0d;
  logic        clk;
  logic        resetn;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire         irq_o;
  wire         sda_o;
  wire         sda_oe;
  wire         scl;
  wire         sda_pull;
  wire         sda_line = !(sda_pull || (sda_oe && !sda_o));
  int          n_fail;
  int          check_count;
  logic [7:0]  exp_q[$];
  logic [7:0]  b[6];
  logic [7:0]  got;
  logic [7:0]  flg;
  logic [1:0]  id;
  logic        ack;

  sic_top #(.ADDR_HIGH(AH)) DUT (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
  sic_i2c_mst u_mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----
  // Classic bus cycle: hold until ack is sampled, then release
  // ----
  task automatic wb(input logic [5:0] i, input logic we, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h00_0000, d};
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    // A slave that never answers ends the run through the verdict
    if (n >= 50)
    begin
      n_fail++;
      test_done;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    wb(i, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    wb(i, 1'b0, 8'h00, 4'hf);
  endtask

  task automatic addr(input logic [1:0] a, input logic rw, input logic e);
    u_mst.start;
    u_mst.wr_byte({AH, a, rw}, ack);
    check(ack, e);
  endtask

  always @(posedge clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check(wb_dat_o, {24'h00_0000, exp_q.pop_front()});
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end

  initial
  begin
    resetn = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    n_fail = 0;
    check_count = 0;
    void'($urandom(46));
    for (int k = 0; k < 6; k++) b[k] = 8'($urandom);
    id = 2'($urandom);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`SIC_IDX_TX_FIRST, 8'h00);
    rd(`SIC_IDX_TX_SECOND, 8'h00);
    rd(`SIC_IDX_CTRL, 8'h00);
    rd(`SIC_IDX_FLAGS, 8'h00);
    rd(`SIC_IDX_IRQ_MASK, 8'h7f);
    wr(6'h05, 8'hff);
    rd(6'h05, 8'h00);
    wr(`SIC_IDX_TX_FIRST, b[4]);
    wr(`SIC_IDX_TX_SECOND, b[5]);
    wb(`SIC_IDX_TX_FIRST, 1'b1, ~b[4], 4'he);
    rd(`SIC_IDX_TX_FIRST, b[4]);
    rd(`SIC_IDX_TX_SECOND, b[5]);
    wr(`SIC_IDX_CTRL, 8'hf7);
    rd(`SIC_IDX_CTRL, 8'h13);
    addr(2'b11, 1'b0, 1'b0);
    u_mst.stop;
    wr(`SIC_IDX_CTRL, {3'b000, 2'b11, 1'b0, id});
    addr(~id, 1'b0, 1'b0);
    u_mst.stop;
    // Four bytes unread: both slots overflow
    addr(id, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      u_mst.wr_byte(b[k], ack);
      check(ack, 1'b1);
    end
    u_mst.stop;
    rd(`SIC_IDX_FLAGS, 8'h4f);
    check(irq_o, 1'b1);
    rd(`SIC_IDX_RX_FIRST, b[2]);
    rd(`SIC_IDX_RX_SECOND, b[3]);
    addr(id, 1'b1, 1'b1);
    u_mst.rd_byte(1'b0, got);
    check(got, b[4]);
    u_mst.rd_byte(1'b1, got);
    check(got, b[5]);
    u_mst.stop;
    rd(`SIC_IDX_FLAGS, 8'h7f);
    wr(`SIC_IDX_CTRL, {3'b000, 2'b01, 1'b0, id});
    @(posedge clk);
    check(irq_o, 1'b0);
    wr(`SIC_IDX_CTRL, {3'b000, 2'b11, 1'b0, id});
    wr(`SIC_IDX_IRQ_MASK, 8'h00);
    @(posedge clk);
    check(irq_o, 1'b0);
    wr(`SIC_IDX_IRQ_MASK, 8'h7f);
    @(posedge clk);
    check(irq_o, 1'b1);
    // Clear one flag at a time; ones written elsewhere must not clear
    flg = 8'h7f;
    for (int k = 0; k < 7; k++)
    begin
      flg[k] = 1'b0;
      wr(`SIC_IDX_FLAGS, ~(8'h01 << k));
      rd(`SIC_IDX_FLAGS, flg);
    end
    @(posedge clk);
    check(irq_o, 1'b0);
    test_done;
  end
endmodule // tb_slave_i2c_register_interface
